// >>> inc/t1a_pkg.sv
// t1a timer package: register map, field layouts, reset values
package t1a_pkg;

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CNT_LOW = 8'h00;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_CMP0_VAL = 8'h18;
    localparam logic [7:0] ADDR_CMP0_MODE = 8'h1C;
    localparam logic [7:0] ADDR_CMP1_VAL = 8'h20;
    localparam logic [7:0] ADDR_CMP1_MODE = 8'h24;

    // --------------------------------------------------------------
    // field layouts
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] prescale;
        logic osc_en;
        logic sync_bypass;
        logic clk_sel;
        logic run;
    } t1a_ctrl_s;

    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] value;
    } t1a_cmp_s;

    // status, clear and enable share this layout
    localparam int NUM_EVT = 2;
    localparam int EVT_OVF = 0;
    localparam int EVT_TRIG = 1;

    // --------------------------------------------------------------
    // reset values and codes
    // --------------------------------------------------------------
    localparam t1a_ctrl_s CTRL_RESET = 8'h00;
    localparam t1a_cmp_s CMP_RESET = 20'h00000;
    localparam logic [NUM_EVT-1:0] EVT_RESET = 2'h0;
    localparam logic [3:0] CMP_MODE_TRIG = 4'hB;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// >>> core/t1a_sync2.sv
// t1a two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module t1a_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // asynchronous in, synchronised out
    input logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// >>> core/t1a_prescaler.sv
// t1a counter prescaler: 1:1, 1:2, 1:4 or 1:8 tick divider
`timescale 1ns/100ps
module t1a_prescaler #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // tick in, divided pulse out
    input logic tick,
    input logic [1:0] sel,
    input logic clr,
    output logic pulse
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] mask;

    assign mask = WIDTH'((4'h1 << sel) - 4'h1);
    assign pulse = tick && ((cnt_reg & mask) == mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (clr) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= cnt_reg + WIDTH'(1);
        end
    end

    a_pre_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clr |=> cnt_reg == '0)
        else $error("prescaler not cleared by count write");
endmodule

// >>> core/t1a_timer.sv
// t1a 16-bit timer/counter with AHB-Lite register slave
`timescale 1ns/100ps

// How it works
// - byte reads always return coherent values
// - write during increment gives no guaranteed value
// - oscillator runs only while enable bit set
// - oscillator keeps running during sleep
// - trigger-mode compare match clears the count
// - trigger clear never sets overflow flag
// - trigger clear only in synchronised modes
// - count write beats simultaneous trigger
// - compare value acts as counter period
// - count bytes survive every reset
// - power-on reset zeroes control register
// - bypass bit counts external edges unaligned
// - async mode gives no compare time base
// - count write clears the prescaler
module t1a_timer (
    // clock and power-on/brown-out reset
    input logic clk,
    input logic rst_n,
    // ahb-lite slave
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic hready,
    input logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // oscillator pins and core state
    input logic osc_input_pin,
    output logic osc_amp_enable,
    input logic sleep,
    // interrupt
    output logic irq
);

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    t1a_pkg::t1a_ctrl_s ctrl_reg;
    t1a_pkg::t1a_cmp_s cmp_reg [2];
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [t1a_pkg::NUM_EVT-1:0] status_reg;
    logic [t1a_pkg::NUM_EVT-1:0] enable_reg;
    logic [t1a_pkg::NUM_EVT-1:0] evt;
    logic [t1a_pkg::NUM_EVT-1:0] clr_mask;
    logic [7:0] addr_reg;
    logic wr_pend_reg;
    logic rd_wait_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_enable;
    logic sw_cnt_wr;
    logic ext_sync;
    logic ext_prev_reg;
    logic ext_rise;
    logic sync_pend_reg;
    logic [1:0] instr_cnt_reg;
    logic instr_tick;
    logic async_mode;
    logic src_tick;
    logic pre_in;
    logic inc_tick;
    logic [1:0] match;
    logic trig;
    logic ovf_evt;

    // --------------------------------------------------------------
    // ahb-lite address and data phase
    // --------------------------------------------------------------
    assign addr_ok = hsel && htrans[1] && hready;

    // reads take one wait state so a write just before is seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_wait_reg <= addr_ok && !hwrite;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= 8'h00;
        end else if (addr_ok) begin
            addr_reg <= haddr[7:0];
        end
    end

    assign hreadyout = !rd_wait_reg;
    assign hresp = t1a_pkg::HRESP_OKAY;
    assign hrdata = hrdata_reg;

    // --------------------------------------------------------------
    // write strobes
    // --------------------------------------------------------------
    assign wr_low = wr_pend_reg && addr_reg == t1a_pkg::ADDR_CNT_LOW;
    assign wr_high = wr_pend_reg && addr_reg == t1a_pkg::ADDR_CNT_HIGH;
    assign wr_ctrl = wr_pend_reg && addr_reg == t1a_pkg::ADDR_CTRL;
    assign wr_clear = wr_pend_reg && addr_reg == t1a_pkg::ADDR_CLEAR;
    assign wr_enable = wr_pend_reg && addr_reg == t1a_pkg::ADDR_ENABLE;
    assign sw_cnt_wr = wr_low || wr_high;

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    // count bytes are plain clk-domain flops, so a read is coherent
    always_comb begin
        rd_mux = 32'h00000000;
        case (addr_reg)
            t1a_pkg::ADDR_CNT_LOW: begin
                rd_mux[7:0] = count_reg[7:0];
            end
            t1a_pkg::ADDR_CNT_HIGH: begin
                rd_mux[7:0] = count_reg[15:8];
            end
            t1a_pkg::ADDR_CTRL: begin
                rd_mux[7:0] = ctrl_reg;
            end
            t1a_pkg::ADDR_STATUS: begin
                rd_mux[t1a_pkg::NUM_EVT-1:0] = status_reg;
            end
            t1a_pkg::ADDR_ENABLE: begin
                rd_mux[t1a_pkg::NUM_EVT-1:0] = enable_reg;
            end
            t1a_pkg::ADDR_CMP0_VAL: begin
                rd_mux[15:0] = cmp_reg[0].value;
            end
            t1a_pkg::ADDR_CMP0_MODE: begin
                rd_mux[3:0] = cmp_reg[0].mode;
            end
            t1a_pkg::ADDR_CMP1_VAL: begin
                rd_mux[15:0] = cmp_reg[1].value;
            end
            t1a_pkg::ADDR_CMP1_MODE: begin
                rd_mux[3:0] = cmp_reg[1].mode;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_wait_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    // --------------------------------------------------------------
    // control and compare registers
    // --------------------------------------------------------------
    // only power-on/brown-out reaches rst_n; other resets leave it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= t1a_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= t1a_pkg::t1a_ctrl_s'({2'h0, hwdata[5:0]});
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_reg[0] <= t1a_pkg::CMP_RESET;
            cmp_reg[1] <= t1a_pkg::CMP_RESET;
        end else if (wr_pend_reg) begin
            unique case (addr_reg)
                t1a_pkg::ADDR_CMP0_VAL: cmp_reg[0].value <= hwdata[15:0];
                t1a_pkg::ADDR_CMP0_MODE: cmp_reg[0].mode <= hwdata[3:0];
                t1a_pkg::ADDR_CMP1_VAL: cmp_reg[1].value <= hwdata[15:0];
                t1a_pkg::ADDR_CMP1_MODE: cmp_reg[1].mode <= hwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // oscillator enable
    // --------------------------------------------------------------
    // sleep is deliberately not looked at here
    assign osc_amp_enable = ctrl_reg.osc_en;

    // --------------------------------------------------------------
    // clock sources
    // --------------------------------------------------------------
    t1a_sync2 #(
        .WIDTH(1)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(osc_input_pin),
        .q(ext_sync)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_sync;
        end
    end

    assign ext_rise = ext_sync && !ext_prev_reg;

    // instruction-rate enable: one pulse every four clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instr_cnt_reg <= 2'h0;
        end else begin
            instr_cnt_reg <= instr_cnt_reg + 2'h1;
        end
    end

    assign instr_tick = instr_cnt_reg == t1a_pkg::INSTR_DIV_LAST;
    assign async_mode = ctrl_reg.clk_sel && ctrl_reg.sync_bypass;

    // synchronised mode holds an edge until the next instruction
    // phase; bypass mode counts it at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_pend_reg <= 1'b0;
        end else if (instr_tick) begin
            sync_pend_reg <= 1'b0;
        end else if (ext_rise) begin
            sync_pend_reg <= 1'b1;
        end
    end

    always_comb begin
        if (!ctrl_reg.clk_sel) begin
            src_tick = instr_tick;
        end else if (ctrl_reg.sync_bypass) begin
            src_tick = ext_rise;
        end else begin
            src_tick = instr_tick && (sync_pend_reg || ext_rise);
        end
    end

    // only the unsynchronised counter keeps going in sleep
    assign pre_in = src_tick && ctrl_reg.run && (!sleep || async_mode);

    t1a_prescaler #(
        .WIDTH(3)
    ) u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .tick(pre_in),
        .sel(ctrl_reg.prescale),
        .clr(sw_cnt_wr),
        .pulse(inc_tick)
    );

    // --------------------------------------------------------------
    // special event trigger
    // --------------------------------------------------------------
    // async mode: no trigger at all rather than an unreliable one
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            match[i] = cmp_reg[i].mode == t1a_pkg::CMP_MODE_TRIG &&
                count_reg == cmp_reg[i].value;
        end
    end

    assign trig = (|match) && ctrl_reg.run && !async_mode;

    // --------------------------------------------------------------
    // count
    // --------------------------------------------------------------
    // a write beats both the trigger and an increment; this makes
    // the write/increment collision defined, though not promised
    always_comb begin
        count_next = count_reg;
        if (wr_low) begin
            count_next[7:0] = hwdata[7:0];
        end else if (wr_high) begin
            count_next[15:8] = hwdata[7:0];
        end else if (trig) begin
            count_next = 16'h0000;
        end else if (inc_tick) begin
            count_next = count_reg + 16'h0001;
        end
    end

    // no reset: the count is kept through every reset
    always_ff @(posedge clk) begin
        count_reg <= count_next;
    end

    // --------------------------------------------------------------
    // events and interrupt
    // --------------------------------------------------------------
    assign ovf_evt = inc_tick && count_reg == t1a_pkg::COUNT_MAX &&
        !sw_cnt_wr && !trig;

    always_comb begin
        evt = t1a_pkg::EVT_RESET;
        evt[t1a_pkg::EVT_OVF] = ovf_evt;
        evt[t1a_pkg::EVT_TRIG] = trig && !sw_cnt_wr;
    end

    assign clr_mask = wr_clear ? hwdata[t1a_pkg::NUM_EVT-1:0]
        : t1a_pkg::EVT_RESET;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= t1a_pkg::EVT_RESET;
        end else begin
            status_reg <= (status_reg & ~clr_mask) | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_reg <= t1a_pkg::EVT_RESET;
        end else if (wr_enable) begin
            enable_reg <= hwdata[t1a_pkg::NUM_EVT-1:0];
        end
    end

    assign irq = |(status_reg & enable_reg);

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_wrap;
        inc_tick && count_reg == t1a_pkg::COUNT_MAX && !sw_cnt_wr && !trig;
    endsequence

    sequence s_trig_clear;
        trig && !sw_cnt_wr;
    endsequence

    a_trig_clears: assert property (@(posedge clk) disable iff (!rst_n)
        s_trig_clear |=> count_reg == 16'h0000)
        else $error("trigger did not clear count");

    a_trig_no_ovf: assert property (@(posedge clk) disable iff (!rst_n)
        s_trig_clear ##0 !status_reg[0] |=> !status_reg[0])
        else $error("trigger set overflow flag");

    a_async_no_trig: assert property (@(posedge clk) disable iff (!rst_n)
        async_mode |-> !trig)
        else $error("trigger fired in async mode");

    a_write_wins: assert property (@(posedge clk) disable iff (!rst_n)
        wr_low && trig |=> count_reg[7:0] == $past(hwdata[7:0]))
        else $error("trigger overrode count write");

    a_ctrl_por: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> ctrl_reg == 8'h00)
        else $error("control not zero after power-on reset");

    a_ovf_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        s_wrap |=> count_reg == 16'h0000 && status_reg[0])
        else $error("wrap did not set overflow flag");

    a_ovf_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(status_reg[0]) |-> $past(inc_tick) &&
            $past(count_reg) == 16'hFFFF)
        else $error("overflow flag set without wrap");

    a_low_no_carry: assert property (@(posedge clk) disable iff (!rst_n)
        wr_low |=> count_reg[15:8] == $past(count_reg[15:8]))
        else $error("low byte write changed high byte");

    a_osc_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_reg.osc_en && sleep |-> osc_amp_enable)
        else $error("oscillator stopped in sleep");

    a_osc_off: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(ctrl_reg.osc_en) |-> !osc_amp_enable)
        else $error("oscillator runs while disabled");

    a_bypass_edge: assert property (@(posedge clk) disable iff (!rst_n)
        async_mode && ctrl_reg.run && ext_rise &&
            ctrl_reg.prescale == 2'h0 |-> inc_tick)
        else $error("bypass edge not counted at once");

    a_period: assert property (@(posedge clk) disable iff (!rst_n)
        match[0] && ctrl_reg.run && !async_mode && !sw_cnt_wr
            |=> count_reg == 16'h0000)
        else $error("compare match did not restart count");

endmodule

// >>> verification/t1a_osc_model.sv
// t1a external crystal model: square wave while the block enables it
`timescale 1ns/100ps
module t1a_osc_model #(
    parameter int HALF_NS = 200
) (
    // enable from the block
    input logic osc_amp_enable,
    // clock toward the block
    output logic osc_input_pin
);
    // ----------------------------------------------------------
    // crystal
    // ----------------------------------------------------------
    // a stopped crystal rests low, never toggling between frames
    initial begin
        osc_input_pin = 1'b0;
        #37;
        forever begin
            if (osc_amp_enable === 1'b1) begin
                #(HALF_NS) osc_input_pin = ~osc_input_pin;
            end else begin
                osc_input_pin = 1'b0;
                @(osc_amp_enable);
            end
        end
    end
endmodule

// >>> verification/test_t1a_timer.sv
// t1a timer testbench: registers, counting, trigger, reset
`timescale 1ns/100ps
module test_t1a_timer;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic clk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic osc_input_pin;
    logic osc_amp_enable;
    logic sleep;
    logic irq;
    int mismatches;
    int checks_done;
    logic [31:0] rd;
    logic [15:0] cnt;
    typedef struct {
        logic [7:0] addr;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } t1a_row_s;
    t1a_row_s rows [12] = '{
        '{t1a_pkg::ADDR_CTRL, 1'b0, 32'h0, 32'h0},
        '{t1a_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h0},
        '{t1a_pkg::ADDR_ENABLE, 1'b0, 32'h0, 32'h0},
        '{t1a_pkg::ADDR_CTRL, 1'b1, 32'hFE, 32'h3E},
        '{t1a_pkg::ADDR_CTRL, 1'b1, 32'h0, 32'h0},
        '{t1a_pkg::ADDR_CMP0_VAL, 1'b1, 32'hABCD1234, 32'h1234},
        '{t1a_pkg::ADDR_CMP1_MODE, 1'b1, 32'hA5, 32'h5},
        '{t1a_pkg::ADDR_CNT_HIGH, 1'b1, 32'h12, 32'h12},
        '{t1a_pkg::ADDR_CNT_LOW, 1'b1, 32'hFF, 32'hFF},
        '{t1a_pkg::ADDR_CNT_LOW, 1'b0, 32'h0, 32'hFF},
        '{8'h40, 1'b1, 32'hFFFFFFFF, 32'h0},
        '{t1a_pkg::ADDR_STATUS, 1'b1, 32'h3, 32'h0}
    };

    // ----------------------------------------------------------
    // design and crystal
    // ----------------------------------------------------------
    t1a_timer t1a_timer_inst (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .osc_input_pin(osc_input_pin), .osc_amp_enable(osc_amp_enable),
        .sleep(sleep), .irq(irq)
    );
    t1a_osc_model t1a_osc_model_inst (
        .osc_amp_enable(osc_amp_enable),
        .osc_input_pin(osc_input_pin)
    );

    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("[FAIL] %0t bus stuck", $time);
        end
    endtask

    // one single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    // high, low, high; retry once if the high byte moved
    task automatic read_count();
        logic [7:0] h;
        bus(1'b0, t1a_pkg::ADDR_CNT_HIGH, 32'h0);
        h = rd[7:0];
        bus(1'b0, t1a_pkg::ADDR_CNT_LOW, 32'h0);
        cnt = {h, rd[7:0]};
        bus(1'b0, t1a_pkg::ADDR_CNT_HIGH, 32'h0);
        if (rd[7:0] !== h) begin
            h = rd[7:0];
            bus(1'b0, t1a_pkg::ADDR_CNT_LOW, 32'h0);
            cnt = {h, rd[7:0]};
        end
    endtask

    task automatic load_count(input logic [15:0] v);
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h0);
        bus(1'b1, t1a_pkg::ADDR_CNT_HIGH, {24'h0, v[15:8]});
        bus(1'b1, t1a_pkg::ADDR_CNT_LOW, {24'h0, v[7:0]});
        bus(1'b1, t1a_pkg::ADDR_CLEAR, 32'h3);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #1000000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        sleep = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                bus(1'b1, rows[i].addr, rows[i].wdata);
            end
            bus(1'b0, rows[i].addr, 32'h0);
            check(rd, rows[i].exp);
        end
        // oscillator enable, also while asleep
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h8);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        check({31'h0, osc_amp_enable}, 32'h1);
        sleep <= 1'b0;
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h0);
        @(posedge clk);
        check({31'h0, osc_amp_enable}, 32'h0);
        // wrap by counting, then mask and clear the interrupt
        load_count(16'hFFFE);
        bus(1'b1, t1a_pkg::ADDR_ENABLE, 32'h1);
        // 1:2 prescale, so the divider path is exercised as well
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h11);
        repeat (20) @(posedge clk);
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h0);
        read_count();
        check({24'h0, cnt[15:8]}, 32'h0);
        bus(1'b0, t1a_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h1);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, t1a_pkg::ADDR_ENABLE, 32'h0);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, t1a_pkg::ADDR_ENABLE, 32'h1);
        @(posedge clk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, t1a_pkg::ADDR_CLEAR, 32'h1);
        bus(1'b0, t1a_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        // each compare unit in trigger mode sets the period
        for (int u = 0; u < 2; u++) begin
            load_count(16'h0);
            bus(1'b1, u ? t1a_pkg::ADDR_CMP0_MODE
                        : t1a_pkg::ADDR_CMP1_MODE, 32'h0);
            bus(1'b1, u ? t1a_pkg::ADDR_CMP1_VAL
                        : t1a_pkg::ADDR_CMP0_VAL, 32'h5);
            bus(1'b1, u ? t1a_pkg::ADDR_CMP1_MODE : t1a_pkg::ADDR_CMP0_MODE,
                {28'h0, t1a_pkg::CMP_MODE_TRIG});
            bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h1);
            repeat (100) @(posedge clk);
            bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h0);
            read_count();
            check({31'h0, cnt <= 16'h5}, 32'h1);
            bus(1'b0, t1a_pkg::ADDR_STATUS, 32'h0);
            check(rd, 32'h2);
        end
        // count write at the edge of a standing trigger
        load_count(16'h0);
        bus(1'b1, t1a_pkg::ADDR_CMP1_VAL, 32'h0);
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h1);
        bus(1'b1, t1a_pkg::ADDR_CNT_LOW, 32'h42);
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h0);
        read_count();
        check({31'h0, cnt >= 16'h42}, 32'h1);
        // pin counting: unsynchronised asleep, then synchronised
        bus(1'b1, t1a_pkg::ADDR_CMP1_VAL, 32'h2);
        for (int m = 0; m < 2; m++) begin
            load_count(16'h0);
            bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h8);
            repeat (40) @(posedge clk);
            sleep <= (m == 0);
            bus(1'b1, t1a_pkg::ADDR_CTRL, m ? 32'hB : 32'hF);
            repeat (160) @(posedge clk);
            bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h0);
            sleep <= 1'b0;
            read_count();
            bus(1'b0, t1a_pkg::ADDR_STATUS, 32'h0);
            if (m == 0) begin
                check({31'h0, (cnt - 16'h12) <= 16'h4}, 32'h1);
                check(rd, 32'h0);
            end else begin
                check({31'h0, cnt <= 16'h2}, 32'h1);
                check(rd, 32'h2);
            end
        end
        // power-on reset keeps the count, zeroes control
        load_count(16'h5AA5);
        bus(1'b1, t1a_pkg::ADDR_CTRL, 32'h3E);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        read_count();
        check({16'h0, cnt}, 32'h5AA5);
        bus(1'b0, t1a_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        check({31'h0, osc_amp_enable}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        test_done();
    end
endmodule
